/* File: core/asrb_map.vh */
/*
  Register map, field positions, reset values and timing counts of the
  arming and status register bank.
  Assumes inclusion by bare name from the bank's design files.
*/
`ifndef ASRB_MAP_VH
`define ASRB_MAP_VH

// ============================================================
// Register offsets
`define ASRB_OFS_ARM_POS 8'h10
`define ASRB_OFS_ARM_NEG 8'h12
`define ASRB_OFS_STATUS 8'h14
`define ASRB_OFS_COUNTER 8'h15
`define ASRB_OFS_DRIFT 8'h16
`define ASRB_OFS_SPARE_A 8'h1c
`define ASRB_OFS_SPARE_B 8'h1d

// ============================================================
// Status bit positions
`define ASRB_ST_RESET_OCC 0
`define ASRB_ST_OFFSET 1
`define ASRB_ST_ZERO 2
`define ASRB_ST_MISMATCH 3
`define ASRB_ST_INIT 4
`define ASRB_ST_UNUSED_A 5
`define ASRB_ST_DATA_ERR 6
`define ASRB_ST_UNUSED_B 7

// ============================================================
// Reset values and constants
`define ASRB_RST_BYTE 8'h00
`define ASRB_THR_OFF 8'h00
`define ASRB_CRC_SEED 3'h7
`define ASRB_CRC_POLY 3'h3
`define ASRB_PRESCALE_DIV 1024
`define ASRB_STEP_NS 128000
`define ASRB_CLK_NS 100
`define ASRB_INIT_CYCLES 16
`endif

/* File: core/asrb_crc3.v */
/*
  Serial 3-bit CRC engine, polynomial x^3+x+1, MSB first.
  Assumes the caller pulses start_in, then presents one bit per cycle
  with bit_en_in high; crc_out holds the running remainder.
*/
`timescale 1ns/10ps
`include "asrb_map.vh"

module asrb_crc3 (
  input wire mclk_in,          // Bank clock
  input wire rst_in,           // Synchronous reset, high
  input wire start_in,         // Reload the seed
  input wire bit_en_in,        // Shift one data bit in
  input wire bit_in,           // Data bit, MSB first
  output reg [2:0] crc_out     // Running remainder
);
  wire fb;
  assign fb = crc_out[2] ^ bit_in;

  always @(posedge mclk_in) begin
    if (rst_in || start_in) begin
      crc_out <= `ASRB_CRC_SEED;
    end else if (bit_en_in) begin
      crc_out <= {crc_out[1:0], 1'b0} ^ (fb ? `ASRB_CRC_POLY : 3'h0);
    end
  end
endmodule // asrb_crc3

/* File: core/asrb_bank.v */
/*
  Arming threshold and device status register bank with its oscillator
  check counter and two CRC checkers (factory shadow and writable set).
  Assumes a register port from the serial-link decoder on the same clock,
  one-cycle read and write strobes, and fault events from same-clock logic.
  The shadow array and both stored check values arrive as plain inputs.
*/
`timescale 1ns/10ps
`include "asrb_map.vh"

module asrb_bank #(
  parameter SHADOW_BYTES = 4,                 // Factory shadow array size
  parameter PRESCALE = `ASRB_PRESCALE_DIV,    // Oscillator prescaler
  parameter INIT_CYCLES = `ASRB_INIT_CYCLES   // Internal init duration
) (
  input wire mclk_in,                         // Oscillator clock, 10 MHz
  input wire rst_in,                          // Synchronous reset, high
  input wire [7:0] addr_in,                   // Register address
  input wire wr_in,                           // Write strobe, one cycle
  input wire rd_in,                           // Read strobe, one cycle
  input wire [7:0] wdata_in,                  // Write data
  input wire init_lock_bit_in,                // Init lock from config reg
  input wire mismatch_evt_in,                 // Output mismatch event
  input wire offset_evt_in,                   // Offset limit reached
  input wire other_fault_in,                  // Other internal fault
  input wire [7:0] drift_in,                  // Latest drift correction
  input wire drift_valid_in,                  // Drift correction update
  input wire [8*SHADOW_BYTES-1:0] shadow_in,  // Factory shadow array
  input wire [2:0] shadow_crc_in,             // Stored shadow check value
  input wire [2:0] writable_crc_in,           // Stored writable check value
  output reg [7:0] rdata_out,                 // Read data
  output reg [7:0] positive_threshold_out,    // Positive threshold
  output reg [7:0] negative_threshold_out,    // Negative threshold
  output reg pos_compare_en_out,              // Positive compare enabled
  output reg neg_compare_en_out,              // Negative compare enabled
  output reg arming_en_out,                   // Arming and pin enabled
  output reg init_busy_out                    // Initialisation in progress
);
  localparam SH_BITS = 8 * SHADOW_BYTES;
  localparam WR_BITS = 16;
  localparam TOT_BITS = SH_BITS + WR_BITS;
  localparam CW = 16;
  localparam STEP_CYCLES = `ASRB_STEP_NS / `ASRB_CLK_NS;
  localparam S_IDLE = 2'h0;
  localparam S_SHIFT = 2'h1;
  localparam S_CHECK = 2'h2;

  // ============================================================
  // Writable thresholds
  reg [7:0] positive_threshold_field;
  reg [7:0] negative_threshold_field;
  wire wr_pos;
  wire wr_neg;
  assign wr_pos = wr_in && !init_lock_bit_in &&
                  addr_in == `ASRB_OFS_ARM_POS;
  assign wr_neg = wr_in && !init_lock_bit_in &&
                  addr_in == `ASRB_OFS_ARM_NEG;

  always @(posedge mclk_in) begin
    if (rst_in) begin
      positive_threshold_field <= `ASRB_RST_BYTE;
      negative_threshold_field <= `ASRB_RST_BYTE;
    end else begin
      if (wr_pos) begin
        positive_threshold_field <= wdata_in;
      end
      if (wr_neg) begin
        negative_threshold_field <= wdata_in;
      end
    end
  end

  // Registered copies so the arming engine sees flop outputs only
  always @(posedge mclk_in) begin
    if (rst_in) begin
      positive_threshold_out <= `ASRB_RST_BYTE;
      negative_threshold_out <= `ASRB_RST_BYTE;
      pos_compare_en_out <= 1'b0;
      neg_compare_en_out <= 1'b0;
      arming_en_out <= 1'b0;
    end else begin
      positive_threshold_out <= positive_threshold_field;
      negative_threshold_out <= negative_threshold_field;
      pos_compare_en_out <= positive_threshold_field != `ASRB_THR_OFF;
      neg_compare_en_out <= negative_threshold_field != `ASRB_THR_OFF;
      arming_en_out <= (positive_threshold_field != `ASRB_THR_OFF) ||
                       (negative_threshold_field != `ASRB_THR_OFF);
    end
  end

  // ============================================================
  // Initialisation timer
  reg [CW-1:0] init_cnt;
  reg init_flag;

  always @(posedge mclk_in) begin
    if (rst_in) begin
      init_cnt <= {CW{1'b0}};
      init_flag <= 1'b1;
    end else if (init_flag) begin
      if (init_cnt == INIT_CYCLES[CW-1:0] - 16'h0001) begin
        init_flag <= 1'b0;
      end
      init_cnt <= init_cnt + 16'h0001;
    end
  end

  always @(posedge mclk_in) begin
    if (rst_in) begin
      init_busy_out <= 1'b1;
    end else begin
      init_busy_out <= init_flag;
    end
  end

  // ============================================================
  // Oscillator check counter
  reg [CW-1:0] pre_cnt;
  reg [7:0] osc_count;

  always @(posedge mclk_in) begin
    if (rst_in) begin
      pre_cnt <= {CW{1'b0}};
      osc_count <= `ASRB_RST_BYTE;
    end else if (pre_cnt == PRESCALE[CW-1:0] - 16'h0001) begin
      pre_cnt <= {CW{1'b0}};
      osc_count <= osc_count + 8'h01;
    end else begin
      pre_cnt <= pre_cnt + 16'h0001;
    end
  end

  // ============================================================
  // Drift correction readout
  reg [7:0] drift_correction_value;

  always @(posedge mclk_in) begin
    if (rst_in) begin
      drift_correction_value <= `ASRB_RST_BYTE;
    end else if (drift_valid_in) begin
      drift_correction_value <= drift_in;
    end
  end

  // ============================================================
  // CRC sequencer: shadow bytes then thresholds, one pass after another
  reg [1:0] state;
  reg [CW-1:0] bit_idx;
  wire crc_start;
  reg shadow_fail;
  reg writable_fail;
  wire [TOT_BITS-1:0] crc_stream;
  wire in_shadow;
  wire cur_bit;
  wire [2:0] sh_crc;
  wire [2:0] wr_crc;
  assign crc_stream = {shadow_in, positive_threshold_field,
                       negative_threshold_field};
  // Seed reload in the idle cycle so the first shift is never swallowed
  assign crc_start = state == S_IDLE;
  assign in_shadow = bit_idx < SH_BITS[CW-1:0];
  assign cur_bit = crc_stream[TOT_BITS - 1 - bit_idx];

  asrb_crc3 u_shadow_crc (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .start_in(crc_start),
    .bit_en_in(state == S_SHIFT && in_shadow),
    .bit_in(cur_bit),
    .crc_out(sh_crc)
  );

  asrb_crc3 u_writable_crc (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .start_in(crc_start),
    .bit_en_in(state == S_SHIFT && !in_shadow),
    .bit_in(cur_bit),
    .crc_out(wr_crc)
  );

  always @(posedge mclk_in) begin
    if (rst_in) begin
      state <= S_IDLE;
      bit_idx <= {CW{1'b0}};
      shadow_fail <= 1'b0;
      writable_fail <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          bit_idx <= {CW{1'b0}};
          state <= S_SHIFT;
        end
        S_SHIFT: begin
          if (bit_idx == TOT_BITS[CW-1:0] - 16'h0001) begin
            state <= S_CHECK;
          end
          bit_idx <= bit_idx + 16'h0001;
        end
        S_CHECK: begin
          // Fault is sticky until reset, so it keeps re-raising the flag
          if (sh_crc != shadow_crc_in) begin
            shadow_fail <= 1'b1;
          end
          if (init_lock_bit_in && wr_crc != writable_crc_in) begin
            writable_fail <= 1'b1;
          end
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Status flags: a new event in the read cycle wins over the clear
  reg data_err_flag;
  reg mismatch_flag;
  reg offset_flag;
  reg reset_occ_flag;
  wire stat_rd;
  wire data_err_evt;
  assign stat_rd = rd_in && addr_in == `ASRB_OFS_STATUS;
  assign data_err_evt = shadow_fail || writable_fail || other_fault_in;

  always @(posedge mclk_in) begin
    if (rst_in) begin
      data_err_flag <= 1'b0;
      mismatch_flag <= 1'b0;
      offset_flag <= 1'b0;
      reset_occ_flag <= 1'b1;
    end else begin
      data_err_flag <= data_err_evt | (data_err_flag & ~stat_rd);
      mismatch_flag <= mismatch_evt_in | (mismatch_flag & ~stat_rd);
      offset_flag <= offset_evt_in | (offset_flag & ~stat_rd);
      reset_occ_flag <= reset_occ_flag & ~stat_rd;
    end
  end

  // ============================================================
  // Read port; writes to read-only and spare locations are dropped
  reg [7:0] next_rdata;

  always @* begin
    next_rdata = `ASRB_RST_BYTE;
    if (addr_in == `ASRB_OFS_ARM_POS) begin
      next_rdata = positive_threshold_field;
    end else if (addr_in == `ASRB_OFS_ARM_NEG) begin
      next_rdata = negative_threshold_field;
    end else if (addr_in == `ASRB_OFS_STATUS) begin
      next_rdata[`ASRB_ST_DATA_ERR] = data_err_flag;
      next_rdata[`ASRB_ST_INIT] = init_flag;
      next_rdata[`ASRB_ST_MISMATCH] = mismatch_flag;
      next_rdata[`ASRB_ST_OFFSET] = offset_flag;
      next_rdata[`ASRB_ST_RESET_OCC] = reset_occ_flag;
      next_rdata[`ASRB_ST_ZERO] = 1'b0;
      next_rdata[`ASRB_ST_UNUSED_A] = 1'b0;
      next_rdata[`ASRB_ST_UNUSED_B] = 1'b0;
    end else if (addr_in == `ASRB_OFS_COUNTER) begin
      next_rdata = osc_count;
    end else if (addr_in == `ASRB_OFS_DRIFT) begin
      next_rdata = drift_correction_value;
    end
  end

  always @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_out <= `ASRB_RST_BYTE;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end
  end
endmodule // asrb_bank

/* File: tb/asrb_bank_assertions.sv */
/*
  Port checker for the arming and status register bank.
  Assumes one clock, synchronous high reset, and is bound to asrb_bank.
*/
`timescale 1ns/10ps
module asrb_bank_assertions (
  input wire mclk_in,                     // Clock
  input wire rst_in,                      // Reset
  input wire [7:0] addr_in,               // Address
  input wire wr_in,                       // Write strobe
  input wire rd_in,                       // Read strobe
  input wire [7:0] wdata_in,              // Write data
  input wire init_lock_bit_in,            // Init lock
  input wire mismatch_evt_in,             // Mismatch event
  input wire [7:0] rdata_out,             // Read data
  input wire [7:0] positive_threshold_out, // Positive threshold
  input wire [7:0] negative_threshold_out, // Negative threshold
  input wire pos_compare_en_out,          // Positive enable
  input wire neg_compare_en_out,          // Negative enable
  input wire arming_en_out,               // Arming enable
  input wire init_busy_out                // Init busy
);
  // ============================================================
  // Properties
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  wire st_rd = rd_in && addr_in == 8'h14;

  a_thr_locked: assert property (wr_in && init_lock_bit_in &&
    addr_in == 8'h10 |-> ##2 $stable(positive_threshold_out))
    else $error("locked threshold changed");
  a_pos_write: assert property (wr_in && !init_lock_bit_in &&
    addr_in == 8'h10 |-> ##2 positive_threshold_out == $past(wdata_in, 2))
    else $error("positive threshold not written");
  a_neg_write: assert property (wr_in && !init_lock_bit_in &&
    addr_in == 8'h12 |-> ##2 negative_threshold_out == $past(wdata_in, 2))
    else $error("negative threshold not written");
  a_pos_enable: assert property (pos_compare_en_out ==
    (positive_threshold_out != 8'h00)) else $error("positive enable wrong");
  a_neg_enable: assert property (neg_compare_en_out ==
    (negative_threshold_out != 8'h00)) else $error("negative enable wrong");
  a_arm_enable: assert property (arming_en_out ==
    (pos_compare_en_out || neg_compare_en_out)) else $error("arming wrong");
  a_unused_zero: assert property (st_rd |=> rdata_out[7] == 1'b0 &&
    rdata_out[5] == 1'b0 && rdata_out[2] == 1'b0)
    else $error("unused status bit set");
  a_init_after: assert property ($fell(rst_in) |-> init_busy_out)
    else $error("init flag missing after reset");
  a_init_status: assert property (st_rd |=>
    rdata_out[4] == init_busy_out) else $error("init bit wrong");
  a_mis_flag: assert property (mismatch_evt_in ##1 st_rd |=>
    rdata_out[3]) else $error("mismatch flag missing");
endmodule // asrb_bank_assertions

bind asrb_bank asrb_bank_assertions i_asrb_bank_assertions (
  .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_in(wr_in),
  .rd_in(rd_in), .wdata_in(wdata_in), .init_lock_bit_in(init_lock_bit_in),
  .mismatch_evt_in(mismatch_evt_in), .rdata_out(rdata_out),
  .positive_threshold_out(positive_threshold_out),
  .negative_threshold_out(negative_threshold_out),
  .pos_compare_en_out(pos_compare_en_out),
  .neg_compare_en_out(neg_compare_en_out),
  .arming_en_out(arming_en_out), .init_busy_out(init_busy_out));

/* File: tb/asrb_host_model.sv */
/*
  Register host model: one-cycle read and write strobes.
  Assumes callers enter its tasks just after a rising edge.
*/
`timescale 1ns/10ps
module asrb_host_model (
  input wire mclk_in,         // Bank clock
  input wire [7:0] rdata_in,  // Read data
  output reg [7:0] addr_out,  // Address
  output reg [7:0] wdata_out, // Write data
  output reg wr_out,          // Write strobe
  output reg rd_out           // Read strobe
);
  // ============================================================
  // Access tasks
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // A spare edge after each strobe keeps back-to-back calls glitch free
  task write_reg(input [7:0] a, input [7:0] v);
    begin
      addr_out = a;
      wdata_out = v;
      wr_out = 1'b1;
      @(posedge mclk_in) #1 wr_out = 1'b0;
      @(posedge mclk_in) #1;
    end
  endtask
  task read_reg(input [7:0] a, output [7:0] v);
    begin
      addr_out = a;
      rd_out = 1'b1;
      @(posedge mclk_in) #1 rd_out = 1'b0;
      @(posedge mclk_in) #1 v = rdata_in;
    end
  endtask
endmodule // asrb_host_model

/* File: tb/tb.sv */
/*
  Testbench for the register bank: host calls with expected values.
  Assumes the bank, its map header and the host model are compiled.
*/
`timescale 1ns/10ps
module tb;
  reg mclk_in = 1'b0;
  reg rst_in = 1'b1;
  reg lock = 1'b0;
  reg mis = 1'b0, ofs = 1'b0, oth = 1'b0, dv = 1'b0;
  reg [7:0] drift = 8'h00;
  reg [31:0] sh = 32'hc3a51e77;
  reg [2:0] shc = 3'h0, wrc = 3'h0;
  reg [7:0] d, c0;
  wire [7:0] addr, wdata, rdata, pth, nth;
  wire wr, rd, pen, nen, aen, busy;
  integer fails = 0, comparisons = 0;
  always #50 mclk_in = ~mclk_in;
  // ============================================================
  // Instances
  asrb_bank #(.PRESCALE(4)) i_asrb_bank (.mclk_in(mclk_in),
    .rst_in(rst_in), .addr_in(addr), .wr_in(wr), .rd_in(rd),
    .wdata_in(wdata), .init_lock_bit_in(lock), .mismatch_evt_in(mis),
    .offset_evt_in(ofs), .other_fault_in(oth), .drift_in(drift),
    .drift_valid_in(dv), .shadow_in(sh), .shadow_crc_in(shc),
    .writable_crc_in(wrc), .rdata_out(rdata),
    .positive_threshold_out(pth), .negative_threshold_out(nth),
    .pos_compare_en_out(pen), .neg_compare_en_out(nen),
    .arming_en_out(aen), .init_busy_out(busy));
  asrb_host_model i_asrb_host_model (.mclk_in(mclk_in), .rdata_in(rdata),
    .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  // ============================================================
  // Helpers
  function [2:0] crc3(input [31:0] v, input integer n);
    integer i;
    begin
      crc3 = 3'h7;
      for (i = n - 1; i >= 0; i = i - 1) begin
        crc3 = {crc3[1:0], 1'b0} ^ ((crc3[2] ^ v[i]) ? 3'h3 : 3'h0);
      end
    end
  endfunction
  task chk(input [7:0] s, input [7:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task w(input [7:0] a, input [7:0] v);
    i_asrb_host_model.write_reg(a, v);
  endtask
  task r(input [7:0] a, input [7:0] e);
    begin
      i_asrb_host_model.read_reg(a, d);
      chk(d, e);
    end
  endtask
  task ev(input [2:0] m);
    begin
      {oth, ofs, mis} = m;
      @(posedge mclk_in) #1 {oth, ofs, mis} = 3'h0;
    end
  endtask
  task idle(input integer n);
    begin
      repeat (n) @(posedge mclk_in);
      #1;
    end
  endtask
  task do_reset;
    begin
      rst_in = 1'b1;
      idle(8);
      rst_in = 1'b0;
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // ============================================================
  // Tests
  initial begin
    #1000000;
    fails = fails + 1;
    finish_test;
  end
  initial begin
    shc = crc3(sh, 32);
    wrc = crc3(32'h0, 16);
    @(posedge mclk_in) #1;
    do_reset;
    r(8'h14, 8'h11);
    idle(30);
    r(8'h14, 8'h00);
    r(8'h10, 8'h00);
    $display("test reset done");
    w(8'h10, 8'h64);
    w(8'h12, 8'h00);
    r(8'h10, 8'h64);
    chk({5'h00, aen, nen, pen}, 8'h05);
    w(8'h10, 8'h00);
    w(8'h12, 8'h32);
    r(8'h12, 8'h32);
    chk({5'h00, aen, nen, pen}, 8'h06);
    w(8'h12, 8'h00);
    r(8'h12, 8'h00);
    chk({5'h00, aen, nen, pen}, 8'h00);
    w(8'h10, 8'ha5);
    w(8'h12, 8'h5a);
    idle(60);
    wrc = crc3(32'ha55a, 16);
    lock = 1'b1;
    w(8'h10, 8'hff);
    w(8'h12, 8'hff);
    r(8'h10, 8'ha5);
    r(8'h12, 8'h5a);
    w(8'h14, 8'hff);
    w(8'h15, 8'hff);
    w(8'h16, 8'hff);
    w(8'h1c, 8'h00);
    w(8'h1d, 8'h00);
    idle(60);
    r(8'h14, 8'h00);
    r(8'h16, 8'h00);
    r(8'h1c, 8'h00);
    r(8'h20, 8'h00);
    $display("test thresholds done");
    ev(3'h1);
    r(8'h14, 8'h08);
    r(8'h14, 8'h00);
    ev(3'h2);
    r(8'h14, 8'h02);
    ev(3'h4);
    r(8'h14, 8'h40);
    r(8'h14, 8'h00);
    drift = 8'h3c;
    dv = 1'b1;
    @(posedge mclk_in) #1 dv = 1'b0;
    r(8'h16, 8'h3c);
    i_asrb_host_model.read_reg(8'h15, c0);
    idle(38);
    i_asrb_host_model.read_reg(8'h15, d);
    chk(d - c0, 8'h0a);
    $display("test events done");
    wrc = ~wrc;
    idle(120);
    r(8'h14, 8'h40);
    r(8'h14, 8'h40);
    lock = 1'b0;
    wrc = ~crc3(32'h0, 16);
    do_reset;
    idle(120);
    r(8'h14, 8'h01);
    shc = ~shc;
    idle(120);
    r(8'h14, 8'h40);
    r(8'h14, 8'h40);
    do_reset;
    idle(120);
    r(8'h14, 8'h41);
    $display("test crc done");
    finish_test;
  end
endmodule // tb
